/* verilog/bmsp_ctrl.sv */
`timescale 1ns/10ps
`include "bmsp_defs.svh"

// Contract
// - secondary disables its error amplifier and floats its output
// - primary drives phase clock out half a period after its cycle start
// - secondary switches from the incoming phase clock; resistor only sets slope
// - primary stops phase clock out while pulse skipping
// - interleaved unit locks to a new sync clock after two rising edges
// - enable cycle discharges soft-start then runs a full 2.8 ms soft-start
// - diode emulation turns the low side off on zero-cross detection
// - mode pin high selects pulse skip; low or clocked selects forced
// - pulse skip start-up forces diode emulation until soft-start ends
// - pulse skip to forced transition completes within 1 ms
// - external clock overrides the resistor, accepted up to 2.2 MHz
// - at minimum off-time sync is ignored and frequency drops
// - forced mode locks to a new external clock within 100 us
// - overtemperature stops switching, bias, soft-start, power good; auto restarts; checked only in active and sleep, standby keeps bias on
// - enable below low threshold: shutdown, bias and switching off
// - between thresholds bias runs, no switching; precision comparator needs bias
// - active only with enable high and bias rail good
// - pulse skip: discontinuous below half ripple, continuous otherwise
// - pulse skip only: 16 missed cycles enter sleep
// - role and spread latched at start-up, changed only after enable cycle
// - spread spectrum enabled means no external synchronization
module bmsp_ctrl #(
  parameter int SS_CYC   = `BMSP_SS_CYC,
  parameter int XFER_CYC = `BMSP_XFER_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        enable_lo_in,
  input  wire logic        enable_hi_in,
  input  wire logic        bias_ok_in,
  input  wire logic [1:0]  cfg_role_in,
  input  wire logic        cfg_spread_in,
  input  wire logic        phase_clock_in,
  input  wire logic        zero_cross_in,
  input  wire logic        light_load_in,
  input  wire logic        comp_low_in,
  input  wire logic        min_off_in,
  input  wire logic        thermal_hot_in,
  input  wire logic        thermal_cool_in,
  input  wire logic        vout_ok_in,
  output logic             bias_reg_en,
  output logic             cycle_start,
  output logic             high_side_en,
  output logic             low_side_en,
  output logic             diode_emulation,
  output logic             err_amp_en,
  output logic             compensation_node_oe,
  output logic             slope_from_rset,
  output logic             ss_discharge,
  output logic             ss_done,
  output logic             power_good,
  output logic             phase_clock_out,
  output logic             sleep_mode
);

  localparam int SSW = $clog2(SS_CYC + 1);
  localparam int XW  = $clog2(XFER_CYC + 1);
  localparam logic [11:0] LOCK_CYC = 12'(`BMSP_LOCK_CYC);
  localparam logic [15:0] SYNC_MIN = 16'(`BMSP_SYNC_MIN_PER);

  if (SS_CYC < 1 || XFER_CYC < 1) begin : g_bad_count
    $error("bmsp_ctrl: counts must be at least one cycle");
  end

  // two-flop synchronisers for every pin input
  bmsp_pkg::bmsp_pins_t pins_raw, pins_m, pins;
  assign pins_raw = '{enable_lo_in, enable_hi_in, bias_ok_in, cfg_role_in, cfg_spread_in,
                      phase_clock_in, zero_cross_in, light_load_in, comp_low_in,
                      min_off_in, thermal_hot_in, thermal_cool_in, vout_ok_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_m <= '0;
      pins   <= '0;
    end else begin
      pins_m <= pins_raw;
      pins   <= pins_m;
    end
  end

  // ahb-lite slave, zero wait state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [15:0] prog_period;
  logic [15:0] meas_period;
  logic        take;
  bmsp_pkg::bmsp_status_t status;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & hready & htrans[1];

  function automatic logic [15:0] clamp_period(input logic [15:0] v);
    clamp_period = (v < `BMSP_PER_MIN) ? `BMSP_PER_MIN : v;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_period <= 16'(`BMSP_CTRL_RST);
    end else if (wr_pend && wr_addr == `BMSP_CTRL_OFS) begin
      prog_period <= clamp_period(hwdata[`BMSP_CTRL_PER_MSB:`BMSP_CTRL_PER_LSB]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr)
        `BMSP_CTRL_OFS:   hrdata <= {16'h0000, prog_period};
        `BMSP_STATUS_OFS: hrdata <= status;
        `BMSP_SYNC_OFS:   hrdata <= {16'h0000, meas_period};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // operating state
  bmsp_pkg::bmsp_state_t state, next_state;
  bmsp_pkg::bmsp_cfg_t   cfg;
  logic                  precision_on;
  logic [4:0]            miss_cnt;
  logic                  skip_mode;

  assign precision_on = pins.bias_ok & pins.enable_hi;

  always_comb begin
    next_state = state;
    case (state)
      bmsp_pkg::ST_SHUTDOWN: begin
        if (pins.enable_lo) next_state = bmsp_pkg::ST_STANDBY;
      end
      bmsp_pkg::ST_STANDBY: begin
        if (precision_on) next_state = bmsp_pkg::ST_ACTIVE;
      end
      bmsp_pkg::ST_ACTIVE: begin
        if (pins.thermal_hot) next_state = bmsp_pkg::ST_THERMAL;
        else if (!precision_on) next_state = bmsp_pkg::ST_STANDBY;
        else if (skip_mode && miss_cnt == 5'(`BMSP_MISS_LIMIT))
          next_state = bmsp_pkg::ST_SLEEP;
      end
      bmsp_pkg::ST_SLEEP: begin
        if (pins.thermal_hot) next_state = bmsp_pkg::ST_THERMAL;
        else if (!precision_on) next_state = bmsp_pkg::ST_STANDBY;
        else if (!pins.comp_low || !skip_mode) next_state = bmsp_pkg::ST_ACTIVE;
      end
      bmsp_pkg::ST_THERMAL: begin
        if (pins.thermal_cool) next_state = bmsp_pkg::ST_STANDBY;
      end
      default: next_state = bmsp_pkg::ST_SHUTDOWN;
    endcase
    if (!pins.enable_lo) next_state = bmsp_pkg::ST_SHUTDOWN;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state <= bmsp_pkg::ST_SHUTDOWN;
    else          state <= next_state;
  end

  // role and spread caught when leaving shutdown, held until enable drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{bmsp_pkg::ROLE_STANDALONE, 1'b0};
    end else if (state == bmsp_pkg::ST_SHUTDOWN && pins.enable_lo) begin
      cfg.role   <= (pins.cfg_role == 2'b11) ? bmsp_pkg::ROLE_STANDALONE
                                             : bmsp_pkg::bmsp_role_t'(pins.cfg_role);
      cfg.spread <= pins.cfg_spread & (pins.cfg_role != 2'b10);
    end
  end

  logic run;
  assign run = (state == bmsp_pkg::ST_ACTIVE) || (state == bmsp_pkg::ST_SLEEP);

  // soft-start: discharged whenever not running, full ramp after each enable
  logic [SSW-1:0] ss_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ss_cnt <= '0;
    else if (!run) ss_cnt <= '0;
    else if (ss_cnt != SSW'(SS_CYC)) ss_cnt <= ss_cnt + 1'b1;
  end

  // mode pin: edge detection, period measurement, tied-level detection
  logic        ph_prev;
  logic        ph_edge;
  logic [15:0] since_edge;
  logic        pin_static;
  logic [1:0]  edges_seen;
  logic        period_ok;

  assign ph_edge    = pins.phase_clock & ~ph_prev;
  assign pin_static = (since_edge == `BMSP_STATIC_CYC);

  function automatic logic in_window(input logic [15:0] meas, input logic [15:0] prog);
    logic [18:0] m5;
    logic [18:0] p4;
    logic [18:0] p6;
    m5 = 19'(meas) * 19'd5;
    p4 = 19'(prog) * 19'd4;
    p6 = 19'(prog) * 19'd6;
    in_window = (meas >= SYNC_MIN) && (m5 >= p4) && (m5 <= p6);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_prev     <= 1'b0;
      since_edge  <= 16'h0000;
      meas_period <= 16'h0000;
      edges_seen  <= 2'b00;
    end else begin
      ph_prev <= pins.phase_clock;
      if (ph_edge) begin
        since_edge  <= 16'h0001;
        meas_period <= since_edge;
        if (edges_seen != 2'(`BMSP_LOCK_EDGES)) edges_seen <= edges_seen + 1'b1;
      end else if (!pin_static) begin
        since_edge <= since_edge + 16'h0001;
      end else begin
        edges_seen <= 2'b00;
      end
    end
  end

  assign period_ok = in_window(meas_period, prog_period) ||
                     (cfg.role == bmsp_pkg::ROLE_SECONDARY && meas_period >= SYNC_MIN);

  // mode selection; leaving pulse skip takes the transfer time
  logic          want_skip;
  logic [XW-1:0] xfer_cnt;
  assign want_skip = pin_static & pins.phase_clock;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_mode <= 1'b0;
      xfer_cnt  <= '0;
    end else if (!run || want_skip) begin
      skip_mode <= want_skip;
      xfer_cnt  <= '0;
    end else if (skip_mode) begin
      if (xfer_cnt == XW'(XFER_CYC - 1)) skip_mode <= 1'b0;
      xfer_cnt <= xfer_cnt + 1'b1;
    end
  end

  // lock to an external clock
  logic        sync_usable;
  logic        locked;
  logic [11:0] lock_cnt;
  logic        interleaved;

  assign interleaved = (cfg.role != bmsp_pkg::ROLE_STANDALONE);
  assign sync_usable = !pin_static && !skip_mode && period_ok &&
                       !cfg.spread && !pins.min_off;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked   <= 1'b0;
      lock_cnt <= 12'h000;
    end else if (!run || !sync_usable) begin
      locked   <= 1'b0;
      lock_cnt <= 12'h000;
    end else if (!locked) begin
      if (interleaved && edges_seen == 2'(`BMSP_LOCK_EDGES)) locked <= 1'b1;
      else if (!interleaved && lock_cnt == LOCK_CYC - 12'h001) locked <= 1'b1;
      lock_cnt <= lock_cnt + 12'h001;
    end
  end

  // switching oscillator with optional spread dither
  logic [15:0] osc_cnt;
  logic [15:0] period;
  logic [3:0]  lfsr;
  logic        osc_wrap;
  logic        restart;

  assign period   = (locked ? meas_period : prog_period) +
                    ((cfg.spread && !locked) ? {12'h000, lfsr} : 16'h0000);
  assign osc_wrap = (osc_cnt >= period - 16'h0001) && !pins.min_off;
  assign restart  = (cfg.role == bmsp_pkg::ROLE_SECONDARY)
                  ? (ph_edge && !pins.min_off)
                  : ((locked && ph_edge) || (!locked && osc_wrap));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt <= 16'h0000;
      lfsr    <= 4'h1;
    end else if (!run) begin
      osc_cnt <= 16'h0000;
    end else if (restart) begin
      osc_cnt <= 16'h0000;
      lfsr    <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    end else if (osc_cnt != 16'hffff) begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  // missed cycles while the compensation level is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) miss_cnt <= 5'h00;
    else if (!run || !pins.comp_low || !skip_mode) miss_cnt <= 5'h00;
    else if (restart && miss_cnt != 5'(`BMSP_MISS_LIMIT)) miss_cnt <= miss_cnt + 5'h01;
  end

  // gate and analog control outputs
  logic sw_on;
  logic emulate;
  logic ss_fin;
  assign ss_fin  = (ss_cnt == SSW'(SS_CYC));
  assign sw_on   = (state == bmsp_pkg::ST_ACTIVE) && !(skip_mode && pins.comp_low);
  assign emulate = skip_mode && (!ss_fin || pins.light_load);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bias_reg_en          <= 1'b0;
      cycle_start          <= 1'b0;
      high_side_en         <= 1'b0;
      low_side_en          <= 1'b0;
      diode_emulation      <= 1'b0;
      err_amp_en           <= 1'b0;
      compensation_node_oe <= 1'b0;
      slope_from_rset      <= 1'b0;
      ss_discharge         <= 1'b1;
      ss_done              <= 1'b0;
      power_good           <= 1'b0;
      phase_clock_out      <= 1'b0;
      sleep_mode           <= 1'b0;
    end else begin
      bias_reg_en  <= (state != bmsp_pkg::ST_SHUTDOWN) &&
                      (state != bmsp_pkg::ST_THERMAL);
      cycle_start  <= restart && sw_on;
      high_side_en <= sw_on;
      low_side_en  <= sw_on && !(emulate && pins.zero_cross);
      diode_emulation <= emulate;
      err_amp_en   <= run && (cfg.role != bmsp_pkg::ROLE_SECONDARY);
      compensation_node_oe <= run && (cfg.role != bmsp_pkg::ROLE_SECONDARY);
      slope_from_rset <= (cfg.role == bmsp_pkg::ROLE_SECONDARY);
      ss_discharge <= !run;
      ss_done      <= run && ss_fin;
      power_good   <= run && ss_fin && pins.vout_ok;
      phase_clock_out <= (cfg.role == bmsp_pkg::ROLE_PRIMARY) && sw_on && !skip_mode &&
                         (osc_cnt >= {1'b0, period[15:1]});
      sleep_mode   <= (state == bmsp_pkg::ST_SLEEP);
    end
  end

  // status word
  always_comb begin
    status                 = '0;
    status.state           = state;
    status.role            = cfg.role;
    status.spread          = cfg.spread;
    status.pulse_skip_mode = skip_mode;
    status.locked          = locked;
    status.ss_done         = ss_fin && run;
    status.sleep           = (state == bmsp_pkg::ST_SLEEP);
  end

endmodule // bmsp_ctrl

/* verilog/bmsp_defs.svh */
`ifndef BMSP_DEFS_SVH
`define BMSP_DEFS_SVH

// register byte offsets
`define BMSP_CTRL_OFS        8'h00
`define BMSP_STATUS_OFS      8'h04
`define BMSP_SYNC_OFS        8'h08

// control register fields and reset value
`define BMSP_CTRL_PER_MSB    15
`define BMSP_CTRL_PER_LSB    0
`define BMSP_CTRL_RST        32'h0000_0064
`define BMSP_PER_MIN         16'h0004

// clock rate and documented times
`define BMSP_CLK_KHZ         40000
`define BMSP_SS_TIME_US      2800
`define BMSP_XFER_TIME_US    1000
`define BMSP_LOCK_TIME_US    100
`define BMSP_SYNC_MAX_KHZ    2200
`define BMSP_LOCK_EDGES      2
`define BMSP_MISS_LIMIT      16

// cycle counts derived from the times
`define BMSP_SS_CYC    (`BMSP_SS_TIME_US * (`BMSP_CLK_KHZ / 1000))
`define BMSP_XFER_CYC  (`BMSP_XFER_TIME_US * (`BMSP_CLK_KHZ / 1000))
`define BMSP_LOCK_CYC  (`BMSP_LOCK_TIME_US * (`BMSP_CLK_KHZ / 1000))
`define BMSP_SYNC_MIN_PER \
  ((`BMSP_CLK_KHZ + `BMSP_SYNC_MAX_KHZ - 1) / `BMSP_SYNC_MAX_KHZ)

// no edge on the mode pin for this long means it is tied, not clocked
`define BMSP_STATIC_CYC      16'h0400

`endif

/* verilog/bmsp_pkg.sv */
package bmsp_pkg;

  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_STANDBY  = 3'b001,
    ST_ACTIVE   = 3'b010,
    ST_SLEEP    = 3'b011,
    ST_THERMAL  = 3'b100
  } bmsp_state_t;

  typedef enum logic [1:0] {
    ROLE_STANDALONE = 2'b00,
    ROLE_PRIMARY    = 2'b01,
    ROLE_SECONDARY  = 2'b10
  } bmsp_role_t;

  typedef struct packed {
    bmsp_role_t role;
    logic       spread;
  } bmsp_cfg_t;

  typedef struct packed {
    logic       enable_lo;
    logic       enable_hi;
    logic       bias_ok;
    logic [1:0] cfg_role;
    logic       cfg_spread;
    logic       phase_clock;
    logic       zero_cross;
    logic       light_load;
    logic       comp_low;
    logic       min_off;
    logic       thermal_hot;
    logic       thermal_cool;
    logic       vout_ok;
  } bmsp_pins_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic        sleep;
    logic        ss_done;
    logic        locked;
    logic        pulse_skip_mode;
    logic        spread;
    bmsp_role_t  role;
    logic        rsvd2;
    bmsp_state_t state;
  } bmsp_status_t;

endpackage

/* tb/bmsp_ctrl_sva.sv */
`timescale 1ns/10ps
module bmsp_ctrl_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable_lo_in,
  input wire logic enable_hi_in,
  input wire logic bias_ok_in,
  input wire logic zero_cross_in,
  input wire logic thermal_hot_in,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic bias_reg_en,
  input wire logic cycle_start,
  input wire logic high_side_en,
  input wire logic low_side_en,
  input wire logic diode_emulation,
  input wire logic err_amp_en,
  input wire logic compensation_node_oe,
  input wire logic slope_from_rset,
  input wire logic ss_discharge,
  input wire logic ss_done,
  input wire logic power_good,
  input wire logic sleep_mode
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  shutdown_off_a: assert property (!enable_lo_in [*6] |-> !bias_reg_en)
    else $error("bias on while disabled");
  standby_idle_a: assert property (!enable_hi_in [*6] |->
    !(high_side_en || low_side_en)) else $error("switching below enable threshold");
  bias_gate_a: assert property (!bias_ok_in [*6] |->
    !(high_side_en || low_side_en)) else $error("switching with bias rail low");
  switch_bias_a: assert property (high_side_en |-> bias_reg_en)
    else $error("switching without bias regulator");
  amp_float_a: assert property (slope_from_rset |->
    !(err_amp_en || compensation_node_oe)) else $error("secondary drives compensation");
  zero_cross_a: assert property ((diode_emulation && zero_cross_in) [*5] |->
    !low_side_en) else $error("low side on after reverse current");
  thermal_off_a: assert property (thermal_hot_in [*6] |->
    !(high_side_en || low_side_en || power_good)) else $error("active while hot");
  ss_hold_a: assert property (ss_discharge |-> !ss_done)
    else $error("soft-start done while held low");
  cycle_pulse_a: assert property (cycle_start |=> !cycle_start)
    else $error("cycle start longer than one cycle");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  cover property (sleep_mode);
  cover property (ss_done && power_good);
  cover property ($rose(diode_emulation));
endmodule // bmsp_ctrl_sva

bind bmsp_ctrl bmsp_ctrl_sva bmsp_ctrl_sva_i (.hclk, .hresetn, .enable_lo_in, .enable_hi_in,
  .bias_ok_in, .zero_cross_in, .thermal_hot_in, .hreadyout, .hresp, .bias_reg_en, .cycle_start,
  .high_side_en, .low_side_en, .diode_emulation, .err_amp_en, .compensation_node_oe,
  .slope_from_rset, .ss_discharge, .ss_done, .power_good, .sleep_mode);

/* tb/bmsp_sync_src.sv */
`timescale 1ns/10ps
// mode 0: pin grounded, 1: tied to analog_supply, 2: running sync clock
module bmsp_sync_src (
  output logic             phase_clock_in,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] half_ns
);
  initial begin
    phase_clock_in = 1'b0;
    forever begin
      if (mode == 2'h2) begin
        #(half_ns) phase_clock_in = ~phase_clock_in;
      end else begin
        #1 phase_clock_in = (mode == 2'h1);
      end
    end
  end
endmodule // bmsp_sync_src

/* tb/test_buck_mode_sync_phase_control.sv */
`timescale 1ns/10ps
`include "bmsp_defs.svh"
module test_buck_mode_sync_phase_control;
  localparam logic [31:0] ST = 32'h007, ROLE = 32'h030, SPR = 32'h040, PSK = 32'h080;
  localparam logic [31:0] LCK = 32'h100, SSD = 32'h200, SLP = 32'h400;
  localparam logic [31:0] ACT = 32'(bmsp_pkg::ST_ACTIVE);
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp;
  logic        enable_lo_in = 1'b0, enable_hi_in = 1'b0, bias_ok_in = 1'b0;
  logic [1:0]  cfg_role_in = 2'b00;
  logic        cfg_spread_in = 1'b0, zero_cross_in = 1'b0, light_load_in = 1'b0;
  logic        comp_low_in = 1'b0, min_off_in = 1'b0, vout_ok_in = 1'b0;
  logic        thermal_hot_in = 1'b0, thermal_cool_in = 1'b0, phase_clock_in;
  logic [1:0]  sync_mode = 2'h0;
  logic [15:0] sync_half = 16'h00fa;
  logic        bias_reg_en, cycle_start, high_side_en, low_side_en, diode_emulation;
  logic        err_amp_en, compensation_node_oe, slope_from_rset, ss_discharge, ss_done;
  logic        power_good, phase_clock_out, sleep_mode, pco_q = 1'b0;
  int          errors = 0, comparisons = 0, toggles = 0, starts = 0, t0;

  bmsp_ctrl #(.SS_CYC(200), .XFER_CYC(100)) bmsp_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .enable_lo_in,
    .enable_hi_in, .bias_ok_in, .cfg_role_in, .cfg_spread_in, .phase_clock_in, .zero_cross_in,
    .light_load_in, .comp_low_in, .min_off_in, .thermal_hot_in, .thermal_cool_in, .vout_ok_in,
    .bias_reg_en, .cycle_start, .high_side_en, .low_side_en, .diode_emulation, .err_amp_en,
    .compensation_node_oe, .slope_from_rset, .ss_discharge, .ss_done, .power_good,
    .phase_clock_out, .sleep_mode);
  bmsp_sync_src bmsp_sync_src_i (.phase_clock_in, .mode(sync_mode), .half_ns(sync_half));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    pco_q <= phase_clock_out;
    if (phase_clock_out !== pco_q) toggles <= toggles + 1;
    if (cycle_start) starts <= starts + 1;
  end

  task automatic summarize();
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // polls status until the masked field matches or the cycle budget runs out
  task automatic stat(input string name, input logic [31:0] m, input logic [31:0] v,
                      input int lim);
    int n;
    n = 0;
    bus(1'b0, `BMSP_STATUS_OFS, 32'h0);
    while ((rd & m) !== v && n < lim) begin
      bus(1'b0, `BMSP_STATUS_OFS, 32'h0);
      n += 2;
    end
    check(name, rd & m, v);
  endtask

  initial begin
    #1000000;
    errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `BMSP_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, `BMSP_CTRL_RST);
    bus(1'b1, `BMSP_CTRL_OFS, 32'h1);
    bus(1'b0, `BMSP_CTRL_OFS, 32'h0);
    check("ctrl clamp", rd, 32'(`BMSP_PER_MIN));
    bus(1'b1, `BMSP_CTRL_OFS, 32'h14);
    bus(1'b1, `BMSP_STATUS_OFS, 32'hffff_ffff);
    bus(1'b0, `BMSP_CTRL_OFS, 32'h0);
    check("ctrl period", rd, 32'h14);
    stat("status read only", ST, 32'h0, 0);
    bus(1'b0, 8'h3c, 32'h0);
    check("unmapped", rd, 32'h0);
    // secondary: standby first, then active with amplifier floated
    cfg_role_in <= 2'(bmsp_pkg::ROLE_SECONDARY);
    enable_lo_in <= 1'b1;
    stat("standby", ST, 32'(bmsp_pkg::ST_STANDBY), 40);
    repeat (2) @(posedge hclk);
    check("standby outputs", {bias_reg_en, high_side_en}, 32'h2);
    enable_hi_in <= 1'b1;
    bias_ok_in <= 1'b1;
    stat("secondary active", ST, ACT, 40);
    repeat (2) @(posedge hclk);
    check("secondary amp", {err_amp_en, compensation_node_oe, slope_from_rset},
          32'h1);
    t0 = starts;
    repeat (60) @(posedge hclk);
    check("secondary own osc", 32'(starts - t0), 32'h0);
    sync_mode <= 2'h2;
    repeat (120) @(posedge hclk);
    check("secondary follows", 32'(starts - t0 >= 3), 32'h1);
    sync_mode <= 2'h0;
    cfg_role_in <= 2'(bmsp_pkg::ROLE_PRIMARY);
    // let the mode pin settle as tied so later lock starts from no clock
    repeat (1100) @(posedge hclk);
    stat("role held", ROLE, 32'(bmsp_pkg::ROLE_SECONDARY) << 4, 0);
    enable_lo_in <= 1'b0;
    enable_hi_in <= 1'b0;
    bias_ok_in <= 1'b0;
    stat("shutdown", ST, 32'h0, 40);
    repeat (2) @(posedge hclk);
    check("shutdown outputs", {bias_reg_en, ss_discharge}, 32'h1);
    // primary: enable pins together, bias rail late
    enable_lo_in <= 1'b1;
    enable_hi_in <= 1'b1;
    repeat (40) @(posedge hclk);
    stat("no bias stays standby", ST, 32'(bmsp_pkg::ST_STANDBY), 0);
    bias_ok_in <= 1'b1;
    vout_ok_in <= 1'b1;
    stat("primary active", ST, ACT, 40);
    stat("soft-start done", SSD, SSD, 260);
    repeat (4) @(posedge hclk);
    check("primary amp", {err_amp_en, slope_from_rset, power_good, ss_done},
          32'hb);
    sync_mode <= 2'h2;
    stat("interleaved lock", LCK, LCK, 200);
    t0 = toggles;
    repeat (200) @(posedge hclk);
    check("sync out running", 32'(toggles - t0 >= 10), 32'h1);
    sync_half <= 16'h0064;
    stat("fast clock refused", LCK, 32'h0, 400);
    sync_half <= 16'h00fa;
    sync_mode <= 2'h1;
    light_load_in <= 1'b1;
    stat("pulse skip", PSK, PSK, 1300);
    repeat (4) @(posedge hclk);
    check("diode emulation", 32'(diode_emulation), 32'h1);
    t0 = toggles;
    repeat (100) @(posedge hclk);
    check("sync out stopped", 32'(toggles - t0), 32'h0);
    zero_cross_in <= 1'b1;
    repeat (6) @(posedge hclk);
    check("zero cross", 32'(low_side_en), 32'h0);
    zero_cross_in <= 1'b0;
    comp_low_in <= 1'b1;
    stat("sleep", SLP, SLP, 800);
    check("sleep out", 32'(sleep_mode), 32'h1);
    comp_low_in <= 1'b0;
    light_load_in <= 1'b0;
    sync_mode <= 2'h0;
    stat("forced again", PSK, 32'h0, 1300);
    // over-temperature and automatic restart
    thermal_hot_in <= 1'b1;
    stat("thermal", ST, 32'(bmsp_pkg::ST_THERMAL), 40);
    repeat (2) @(posedge hclk);
    check("thermal outputs", {high_side_en, low_side_en, power_good, bias_reg_en, ss_discharge},
          32'h1);
    thermal_hot_in <= 1'b0;
    thermal_cool_in <= 1'b1;
    stat("restart", ST, ACT, 60);
    stat("restart soft-start", SSD, 32'h0, 0);
    thermal_cool_in <= 1'b0;
    // standalone: spread blocks synchronisation, otherwise lock to the clock
    for (int s = 1; s >= 0; s--) begin
      enable_lo_in <= 1'b0;
      cfg_role_in <= 2'(bmsp_pkg::ROLE_STANDALONE);
      cfg_spread_in <= s[0];
      stat("off", ST, 32'h0, 40);
      sync_mode <= 2'h2;
      enable_lo_in <= 1'b1;
      stat("standalone active", ST, ACT, 40);
      stat("spread latched", SPR, s ? SPR : 32'h0, 0);
      repeat (4300) @(posedge hclk);
      stat("standalone lock", LCK, s ? 32'h0 : LCK, 0);
    end
    min_off_in <= 1'b1;
    stat("min off drops sync", LCK, 32'h0, 20);
    min_off_in <= 1'b0;
    summarize();
  end
endmodule // test_buck_mode_sync_phase_control
